// [dv/pcid_bus_peer.sv]
// far-side bus agent that supplies parity for address and data phases
// assumes phase strobes and bus lines come from the bench on the rising edge
`timescale 1ns/1ns

module pcid_bus_peer (
    input  wire logic        clock,
    input  wire logic [31:0] ad_in,
    input  wire logic [3:0]  cbe_in,
    input  wire logic        phase,
    input  wire logic        flip,
    output logic             par_in
);
    initial par_in = 1'b0;

    // parity trails its phase by one clock; flip corrupts it when the bench asks
    // between phases the line toggles every clock, so it wanders rather than holding
    always @(posedge clock) begin
        if (phase) begin
            par_in <= ^{ad_in, cbe_in} ^ flip;
        end else begin
            par_in <= ~par_in;
        end
    end
endmodule

// [dv/pcid_cfg_regs_asserts.sv]
// concurrent checks on the identity and command register ports
// assumes binding to pcid_cfg_regs with its parameters handed on
`timescale 1ns/1ns
`include "pcid_params.svh"

module pcid_cfg_regs_asserts #(
    parameter bit          ENHANCED_FUNC = 1'b0,
    parameter logic [15:0] MAKER_IDENT   = `PCID_MAKER_IDENT,
    parameter logic [15:0] PART_LEGACY   = `PCID_PART_LEGACY,
    parameter logic [15:0] PART_ENHANCED = `PCID_PART_ENHANCED
) (
    input wire logic                    clock,
    input wire logic                    sys_rst,
    input wire logic                    ce,
    input wire logic                    cfg_valid,
    input wire pcid_pkg::pcid_cfg_req_t cfg_req,
    input wire logic [31:0]             cfg_rdata,
    input wire pcid_pkg::pcid_gate_t    gate,
    input wire logic [15:0]             command_o,
    input wire logic                    drive_valid,
    input wire logic [31:0]             ad_out,
    input wire logic [3:0]              cbe_out,
    input wire logic                    par_o,
    input wire logic                    par_oe,
    input wire logic                    perr_n_o,
    input wire logic                    perr_oe,
    input wire logic                    serr_n_o,
    input wire logic                    serr_oe
);
    localparam logic [15:0] PART = ENHANCED_FUNC ? PART_ENHANCED : PART_LEGACY;
    logic par_exp_q;
    logic oe_exp_q;

    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    // parity expected one clock after each phase, whatever the command holds
    always_ff @(posedge clock) begin
        par_exp_q <= ^{ad_out, cbe_out};
        oe_exp_q  <= drive_valid;
    end

    // ****************************************************************
    // error pin sequences
    // ****************************************************************
    sequence s_perr_tail;
        (perr_n_o && perr_oe) ##1 !perr_oe;
    endsequence
    sequence s_serr_release;
        ##1 serr_n_o;
    endsequence

    // ****************************************************************
    // assertions
    // ****************************************************************
    a_ident_fixed: assert property (ce && cfg_valid && !cfg_req.write &&
        cfg_req.idx == `PCID_IDX_IDENT |=> cfg_rdata == {PART, MAKER_IDENT})
        else $error("identity dword wrong");
    a_cmd_readback: assert property (ce && cfg_valid && !cfg_req.write &&
        cfg_req.idx == `PCID_IDX_CMDSTAT |=> cfg_rdata[15:0] == command_o)
        else $error("command readback differs from command output");
    a_ro_bits_zero: assert property ((command_o & 16'hFCA8) == 16'h0000)
        else $error("read-only command bit set");
    a_fbb_follows: assert property (gate.fast_b2b_any == command_o[`PCID_CMD_FBB])
        else $error("fast back-to-back gate mismatch");
    a_mem_gate: assert property (gate.mem_claim |-> command_o[`PCID_CMD_MEM])
        else $error("memory claimed while disabled");
    a_io_gate: assert property (gate.io_claim |-> command_o[`PCID_CMD_IOS])
        else $error("io claimed while disabled");
    a_master_gate: assert property (gate.master_ok |-> command_o[`PCID_CMD_BM])
        else $error("mastering while disabled");
    a_mwi_gate: assert property (gate.use_mwi |-> command_o[`PCID_CMD_MWI] &&
        command_o[`PCID_CMD_BM])
        else $error("write-invalidate while disabled");
    a_serr_gate: assert property (!serr_n_o |-> serr_oe && command_o[`PCID_CMD_SERR] &&
        command_o[`PCID_CMD_PER] ##0 s_serr_release)
        else $error("system error pin driven wrongly");
    a_perr_pulse: assert property ($fell(perr_n_o) |-> perr_oe && command_o[`PCID_CMD_PER]
        ##1 s_perr_tail)
        else $error("parity error pin pulse wrong");
    a_par_always: assert property (ce |=> {par_oe, par_o} == {oe_exp_q, par_exp_q})
        else $error("generated parity wrong");
endmodule

// [dv/test_pcid_cfg_regs.sv]
// self-checking bench for the identity and command register block
// assumes the package, design, peer and checker files compile before it
`timescale 1ns/1ns
`include "pcid_params.svh"

module test_pcid_cfg_regs;
    logic                    clock, sys_rst, ce, cfg_valid, cfg_ack, flip;
    pcid_pkg::pcid_cfg_req_t cfg_req;
    logic [31:0]             cfg_rdata, ad_out, ad_in;
    logic                    mem_hit, io_hit, master_req, mwi_want, drive_valid;
    pcid_pkg::pcid_gate_t    gate;
    logic [15:0]             command_o;
    logic [3:0]              cbe_out, cbe_in;
    logic                    chk_addr, chk_data, par_in, par_o, par_oe;
    logic                    perr_n_o, perr_oe, serr_n_o, serr_oe, detected_parity_error;
    int                      err_total, n_checks;

    pcid_cfg_regs dut (.clock, .sys_rst, .ce, .cfg_valid, .cfg_req, .cfg_ack, .cfg_rdata,
        .mem_hit, .io_hit, .master_req, .mwi_want, .gate, .command_o, .drive_valid,
        .ad_out, .cbe_out, .chk_addr, .chk_data, .ad_in, .cbe_in, .par_in, .par_o, .par_oe,
        .perr_n_o, .perr_oe, .serr_n_o, .serr_oe, .detected_parity_error);
    pcid_bus_peer peer (.clock, .ad_in, .cbe_in, .phase(chk_addr | chk_data), .flip, .par_in);

    // ****************************************************************
    // common tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one access: request on one edge, answer read just after the next
    task automatic cfg(input logic wr, input logic [5:0] idx, input logic [3:0] be,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clock);
        cfg_valid <= 1'b1;
        cfg_req   <= '{wr, idx, be, wd};
        @(posedge clock);
        cfg_valid <= 1'b0;
        #1;
        rd = cfg_rdata;
        chk(cfg_ack, 1'b1);
    endtask

    task automatic wr_cmd(input logic [15:0] v);
        logic [31:0] rd;
        cfg(1'b1, `PCID_IDX_CMDSTAT, 4'h3, {16'h0000, v}, rd);
    endtask

    task automatic report_and_stop();
        if (err_total == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset_ident();
        logic [31:0] rd;
        chk({perr_n_o, perr_oe, serr_n_o, serr_oe, detected_parity_error}, 5'h14);
        cfg(1'b0, `PCID_IDX_CMDSTAT, 4'hF, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0000);
        cfg(1'b1, `PCID_IDX_IDENT, 4'hF, 32'hFFFF_FFFF, rd);
        cfg(1'b0, `PCID_IDX_IDENT, 4'hF, 32'h0000_0000, rd);
        chk(rd, {`PCID_PART_LEGACY, `PCID_MAKER_IDENT});
        cfg(1'b0, 6'h3F, 4'hF, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0000);
    endtask

    // enable low: a write is neither taken nor answered, so nothing moves
    task automatic t_freeze();
        logic [31:0] rd;
        @(posedge clock);
        ce        <= 1'b0;
        cfg_valid <= 1'b1;
        cfg_req   <= '{1'b1, `PCID_IDX_CMDSTAT, 4'h3, 32'h0000_0002};
        @(posedge clock);
        cfg_valid <= 1'b0;
        #1;
        chk({cfg_ack, command_o}, 17'h00000);
        @(posedge clock);
        ce <= 1'b1;
        cfg(1'b0, `PCID_IDX_CMDSTAT, 4'hF, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0000);
    endtask

    // read-only bits stay clear; a single byte lane leaves the other alone
    task automatic t_cmd_ro();
        logic [31:0] rd;
        wr_cmd(16'h03FF);
        cfg(1'b0, `PCID_IDX_CMDSTAT, 4'hF, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0357);
        cfg(1'b1, `PCID_IDX_CMDSTAT, 4'h1, 32'h0000_0000, rd);
        cfg(1'b0, `PCID_IDX_CMDSTAT, 4'hF, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0300);
    endtask

    // bit 9 is set here on a bus whose targets are all fast back-to-back capable
    task automatic t_gates();
        logic [15:0] cmd [7] = '{16'h0000, 16'h0002, 16'h0001, 16'h0004,
                                 16'h0014, 16'h0010, 16'h0200};
        logic [4:0]  exp [7] = '{5'h00, 5'h08, 5'h04, 5'h02, 5'h03, 5'h00, 5'h10};
        @(posedge clock);
        {mem_hit, io_hit, master_req, mwi_want} <= 4'hF;
        foreach (cmd[i]) begin
            wr_cmd(cmd[i]);
            repeat (2) @(posedge clock);
            #1;
            chk(gate, exp[i]);
            chk(command_o, cmd[i]);
        end
        wr_cmd(16'h0000);
    endtask

    task automatic t_par_gen();
        logic [35:0] v [2] = '{36'h3_0000_0001, 36'h0_8000_0001};
        foreach (v[i]) begin
            @(posedge clock);
            drive_valid       <= 1'b1;
            {cbe_out, ad_out} <= v[i];
            @(posedge clock);
            drive_valid <= 1'b0;
            #1;
            chk({par_oe, par_o}, {1'b1, ^v[i]});
        end
    endtask

    // a corrupted phase, then the pins watched and the status cleared
    task automatic t_err(input logic adr, input logic [15:0] cmd, input logic ep, input logic es);
        logic [31:0] rd;
        logic        sp;
        logic        ss;
        sp = 1'b0;
        ss = 1'b0;
        wr_cmd(cmd);
        @(posedge clock);
        {chk_addr, chk_data, flip} <= {adr, !adr, 1'b1};
        @(posedge clock);
        {chk_addr, chk_data, flip} <= 3'h0;
        repeat (8) begin
            @(posedge clock);
            #1;
            sp |= !perr_n_o;
            ss |= !serr_n_o;
        end
        chk({sp, ss, detected_parity_error}, {ep, es, 1'b1});
        cfg(1'b0, `PCID_IDX_CMDSTAT, 4'hF, 32'h0000_0000, rd);
        chk(rd[31], 1'b1);
        cfg(1'b1, `PCID_IDX_CMDSTAT, 4'h8, 32'h8000_0000, rd);
        cfg(1'b0, `PCID_IDX_CMDSTAT, 4'hF, 32'h0000_0000, rd);
        chk(rd, {16'h0000, cmd});
    endtask

    // ****************************************************************
    // clock, sequence and watchdog
    // ****************************************************************
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial begin
        {sys_rst, ce, cfg_valid, mem_hit, io_hit, master_req, mwi_want} = 7'h60;
        {drive_valid, chk_addr, chk_data, flip} = 4'h0;
        {cfg_req, ad_out, cbe_out, ad_in, cbe_in} = '0;
        {err_total, n_checks} = '0;
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        t_reset_ident();
        t_freeze();
        t_par_gen();
        t_cmd_ro();
        t_gates();
        @(posedge clock);
        ad_in  <= 32'h1234_5678;
        cbe_in <= 4'h6;
        t_err(1'b0, 16'h0000, 1'b0, 1'b0);
        t_err(1'b0, 16'h0040, 1'b1, 1'b0);
        t_err(1'b1, 16'h0140, 1'b0, 1'b1);
        t_err(1'b1, 16'h0100, 1'b0, 1'b0);
        report_and_stop();
    end

    // the run needs well under a thousand cycles; this cuts a hang short
    initial begin
        #50000;
        err_total++;
        report_and_stop();
    end
endmodule

bind pcid_cfg_regs pcid_cfg_regs_asserts #(.ENHANCED_FUNC(ENHANCED_FUNC),
    .MAKER_IDENT(MAKER_IDENT), .PART_LEGACY(PART_LEGACY), .PART_ENHANCED(PART_ENHANCED))
    chk_i (.clock, .sys_rst, .ce, .cfg_valid, .cfg_req, .cfg_rdata, .gate, .command_o,
    .drive_valid, .ad_out, .cbe_out, .par_o, .par_oe, .perr_n_o, .perr_oe, .serr_n_o,
    .serr_oe);

// [hdl/pcid_cfg_regs.sv]
// identity and command registers of one function's configuration header
// assumes config accesses come decoded from target logic on the bus clock
// Summary of operation
// - maker identity word at offset 00h is fixed, writes ignored.
// - part identity word at 02h is fixed; low digit differs per function kind.
// - command register at 04h, all sixteen bits reset to zero.
// - all-zero command leaves only configuration accesses answered.
// - bit 9 lets fast back-to-back go to different agents.
// - bit 8 enables the system error pin driver.
// - address parity error reported only with bits 8 and 6 both set.
// - stepping control bit 7 reads zero and is read-only.
// - bit 6 set gives the normal parity error action with the error pin.
// - bit 6 clear sets detected parity status bit 15, no error pin.
// - parity is always generated on driven transfers.
// - bit 2 gates bus mastering; zero means no accesses started.
// - bit 1 gates response to memory space accesses.
// - bit 0 gates response to I/O space accesses.
// - bit 4 permits write-and-invalidate; otherwise plain memory writes.
`timescale 1ns/1ns
`include "pcid_params.svh"

module pcid_cfg_regs #(
    parameter bit          ENHANCED_FUNC = 1'b0,
    parameter logic [15:0] MAKER_IDENT   = `PCID_MAKER_IDENT,   // arbitrary value
    parameter logic [15:0] PART_LEGACY   = `PCID_PART_LEGACY,   // arbitrary value
    parameter logic [15:0] PART_ENHANCED = `PCID_PART_ENHANCED  // arbitrary value
) (
    input  wire logic                   clock,
    input  wire logic                   sys_rst,
    input  wire logic                   ce,
    input  wire logic                   cfg_valid,
    input  wire pcid_pkg::pcid_cfg_req_t cfg_req,
    output logic                        cfg_ack,
    output logic [31:0]                 cfg_rdata,
    input  wire logic                   mem_hit,
    input  wire logic                   io_hit,
    input  wire logic                   master_req,
    input  wire logic                   mwi_want,
    output pcid_pkg::pcid_gate_t        gate,
    output logic [15:0]                 command_o,
    input  wire logic                   drive_valid,
    input  wire logic [31:0]            ad_out,
    input  wire logic [3:0]             cbe_out,
    input  wire logic                   chk_addr,
    input  wire logic                   chk_data,
    input  wire logic [31:0]            ad_in,
    input  wire logic [3:0]             cbe_in,
    input  wire logic                   par_in,
    output logic                        par_o,
    output logic                        par_oe,
    output logic                        perr_n_o,
    output logic                        perr_oe,
    output logic                        serr_n_o,
    output logic                        serr_oe,
    output logic                        detected_parity_error
);

    // ****************************************************************
    // local constants and storage
    // ****************************************************************
    localparam logic [15:0] PART_IDENT = ENHANCED_FUNC ? PART_ENHANCED : PART_LEGACY;

    logic [15:0] cmd_q;
    logic [15:0] cmd_d;
    logic        dpe_q;
    logic        addr_err;
    logic        data_err;
    logic        perr_fire;
    logic        serr_fire;
    logic        dpe_clear;
    logic        wr_cmdstat;

    // merge one 16-bit half of a write under its two byte enables
    function automatic logic [15:0] merge_half(input logic [15:0] old_v,
                                               input logic [15:0] new_v,
                                               input logic [1:0]  be);
        logic [15:0] res;
        res = old_v;
        if (be[0]) begin
            res[7:0] = new_v[7:0];
        end
        if (be[1]) begin
            res[15:8] = new_v[15:8];
        end
        return res;
    endfunction

    // ****************************************************************
    // configuration write decode
    // ****************************************************************
    // identity dword has no write path at all, so identity writes vanish
    assign wr_cmdstat = cfg_valid && cfg_req.write && (cfg_req.idx == `PCID_IDX_CMDSTAT);

    // read-only and reserved bits are masked out so they stay zero
    always_comb begin
        cmd_d = merge_half(cmd_q, cfg_req.wdata[15:0], cfg_req.be[1:0]) & `PCID_CMD_WR_MASK;
    end

    // status bit 15 is write-one-to-clear through its upper byte lane
    assign dpe_clear = wr_cmdstat && cfg_req.be[3] && cfg_req.wdata[16 + `PCID_STAT_DPE];

    // ****************************************************************
    // command register
    // ****************************************************************
    // every bit clears on reset; reserved bits are not stored
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_q <= `PCID_CMD_RESET;
        end else if (ce && wr_cmdstat) begin
            cmd_q <= cmd_d;
        end
    end

    // ****************************************************************
    // configuration read path and acknowledge
    // ****************************************************************
    // config accesses are answered whatever the command holds
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_ack   <= 1'b0;
            cfg_rdata <= `PCID_ZERO32;
        end else if (ce) begin
            cfg_ack <= cfg_valid;
            if (cfg_valid && !cfg_req.write) begin
                case (cfg_req.idx)
                    `PCID_IDX_IDENT: begin
                        cfg_rdata <= {PART_IDENT, MAKER_IDENT};
                    end
                    `PCID_IDX_CMDSTAT: begin
                        cfg_rdata <= {dpe_q, 15'h0000, cmd_q};
                    end
                    default: begin
                        cfg_rdata <= `PCID_ZERO32;               // unmapped reads zero
                    end
                endcase
            end else begin
                cfg_rdata <= `PCID_ZERO32;
            end
        end
    end

    // ****************************************************************
    // gated enables toward the target and master engines
    // ****************************************************************
    // registered so that a zero command shuts every path the next cycle
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            gate      <= '0;
            command_o <= `PCID_CMD_RESET;
        end else if (ce) begin
            gate.mem_claim    <= mem_hit && cmd_q[`PCID_CMD_MEM];
            gate.io_claim     <= io_hit && cmd_q[`PCID_CMD_IOS];
            gate.master_ok    <= master_req && cmd_q[`PCID_CMD_BM];
            // write-and-invalidate also needs mastering; else plain writes
            gate.use_mwi      <= mwi_want && cmd_q[`PCID_CMD_BM] && cmd_q[`PCID_CMD_MWI];
            gate.fast_b2b_any <= cmd_q[`PCID_CMD_FBB];
            command_o         <= cmd_q;
        end
    end

    // ****************************************************************
    // parity engine: generation is unconditional
    // ****************************************************************
    pcid_parity u_parity (
        .clock       (clock),
        .sys_rst     (sys_rst),
        .ce          (ce),
        .drive_valid (drive_valid),
        .ad_out      (ad_out),
        .cbe_out     (cbe_out),
        .chk_addr    (chk_addr),
        .chk_data    (chk_data),
        .ad_in       (ad_in),
        .cbe_in      (cbe_in),
        .par_in      (par_in),
        .par_o       (par_o),
        .par_oe      (par_oe),
        .addr_err    (addr_err),
        .data_err    (data_err)
    );

    // ****************************************************************
    // parity error response
    // ****************************************************************
    // data errors raise the pin only with response on
    assign perr_fire = data_err && cmd_q[`PCID_CMD_PER];
    // address errors need both enables before the system pin fires
    assign serr_fire = addr_err && cmd_q[`PCID_CMD_PER] && cmd_q[`PCID_CMD_SERR];

    // detected status is sticky; a new error beats a same-cycle clear
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            dpe_q <= 1'b0;
        end else if (ce) begin
            if (addr_err || data_err) begin
                dpe_q <= 1'b1;
            end else if (dpe_clear) begin
                dpe_q <= 1'b0;
            end
        end
    end

    // mirror of the status bit for the function's own logic
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            detected_parity_error <= 1'b0;
        end else if (ce) begin
            detected_parity_error <= dpe_q;
        end
    end

    // ****************************************************************
    // error pin drivers
    // ****************************************************************
    // sustained driver; operation continues with no pin when response is off
    pcid_pin_drv #(
        .OPEN_DRAIN (1'b0)
    ) u_perr (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .ce       (ce),
        .fire     (perr_fire),
        .drive_en (cmd_q[`PCID_CMD_PER]),
        .pin_n_o  (perr_n_o),
        .pin_oe   (perr_oe)
    );

    // open-drain driver enabled only by bit 8
    pcid_pin_drv #(
        .OPEN_DRAIN (1'b1)
    ) u_serr (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .ce       (ce),
        .fire     (serr_fire),
        .drive_en (cmd_q[`PCID_CMD_SERR]),
        .pin_n_o  (serr_n_o),
        .pin_oe   (serr_oe)
    );

endmodule

// [hdl/pcid_params.svh]
// constants for the configuration identity and command register block
// assumes inclusion by the package and the design modules by bare name
`ifndef PCID_PARAMS_SVH
`define PCID_PARAMS_SVH

// ****************************************************************
// configuration dword indices (byte offset divided by four)
// ****************************************************************
`define PCID_IDX_W          6
`define PCID_IDX_IDENT      6'h00
`define PCID_IDX_CMDSTAT    6'h01

// ****************************************************************
// command register fields
// ****************************************************************
`define PCID_CMD_RESET      16'h0000
`define PCID_CMD_WR_MASK    16'h0357
`define PCID_CMD_IOS        0
`define PCID_CMD_MEM        1
`define PCID_CMD_BM         2
`define PCID_CMD_SC         3
`define PCID_CMD_MWI        4
`define PCID_CMD_VGA        5
`define PCID_CMD_PER        6
`define PCID_CMD_STEP       7
`define PCID_CMD_SERR       8
`define PCID_CMD_FBB        9

// ****************************************************************
// status field and identity defaults (identity values are arbitrary)
// ****************************************************************
`define PCID_STAT_DPE       15
`define PCID_MAKER_IDENT    16'h5A5A
`define PCID_PART_LEGACY    16'hA5E1
`define PCID_PART_ENHANCED  16'hA5E2
`define PCID_ZERO16         16'h0000
`define PCID_ZERO32         32'h0000_0000

`endif

// [hdl/pcid_parity.sv]
// even parity generator and checker for address/data plus byte enables
// assumes par lags its ad/cbe phase by one clock, as on the bus
`timescale 1ns/1ns

module pcid_parity (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        ce,
    input  wire logic        drive_valid,
    input  wire logic [31:0] ad_out,
    input  wire logic [3:0]  cbe_out,
    input  wire logic        chk_addr,
    input  wire logic        chk_data,
    input  wire logic [31:0] ad_in,
    input  wire logic [3:0]  cbe_in,
    input  wire logic        par_in,
    output logic             par_o,
    output logic             par_oe,
    output logic             addr_err,
    output logic             data_err
);

    logic expect_q;
    logic pend_addr_q;
    logic pend_data_q;

    // ****************************************************************
    // generation never looks at the response enable, checking may
    // ****************************************************************
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            par_o  <= 1'b0;
            par_oe <= 1'b0;
        end else if (ce) begin
            par_o  <= ^{ad_out, cbe_out};
            par_oe <= drive_valid;
        end
    end

    // ****************************************************************
    // check: hold expected parity one cycle, compare against par_in
    // ****************************************************************
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            expect_q    <= 1'b0;
            pend_addr_q <= 1'b0;
            pend_data_q <= 1'b0;
            addr_err    <= 1'b0;
            data_err    <= 1'b0;
        end else if (ce) begin
            expect_q    <= ^{ad_in, cbe_in};
            pend_addr_q <= chk_addr;
            pend_data_q <= chk_data;
            addr_err    <= pend_addr_q && (expect_q != par_in);
            data_err    <= pend_data_q && (expect_q != par_in);
        end
    end

endmodule

// [hdl/pcid_pin_drv.sv]
// registered driver for one active-low error pin of the bus
// assumes a one-cycle fire request from logic on the same clock
`timescale 1ns/1ns
`include "pcid_params.svh"

module pcid_pin_drv #(
    parameter bit OPEN_DRAIN = 1'b1
) (
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic ce,
    input  wire logic fire,
    input  wire logic drive_en,
    output logic      pin_n_o,
    output logic      pin_oe
);

    logic release_q;

    // ****************************************************************
    // pin drive: low for one cycle, then open drain lets go at once
    // while a sustained driver pushes high for one cycle first
    // ****************************************************************
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pin_n_o   <= 1'b1;
            pin_oe    <= 1'b0;
            release_q <= 1'b0;
        end else if (ce) begin
            if (fire && drive_en) begin
                pin_n_o   <= 1'b0;
                pin_oe    <= 1'b1;
                release_q <= !OPEN_DRAIN;
            end else if (release_q) begin
                pin_n_o   <= 1'b1;   // drive high before tri-state
                pin_oe    <= 1'b1;
                release_q <= 1'b0;
            end else begin
                pin_n_o   <= 1'b1;
                pin_oe    <= 1'b0;
            end
        end
    end

endmodule

// [hdl/pcid_pkg.sv]
// types shared by the configuration identity and command block
// assumes pcid_params.svh is on the include path
`include "pcid_params.svh"

package pcid_pkg;

    // ****************************************************************
    // configuration access request as taken from the target logic
    // ****************************************************************
    typedef struct packed {
        logic                     write;
        logic [`PCID_IDX_W-1:0]   idx;
        logic [3:0]               be;
        logic [31:0]              wdata;
    } pcid_cfg_req_t;

    // ****************************************************************
    // gated enables handed to the bus engines
    // ****************************************************************
    typedef struct packed {
        logic fast_b2b_any;
        logic mem_claim;
        logic io_claim;
        logic master_ok;
        logic use_mwi;
    } pcid_gate_t;

endpackage
